//--- bench/fp_lazy_state_and_privilege_entry_bench.sv
// self-checking bench for the fp lazy state and privilege entry block
// assumes fp_priv_ctrl with its bound monitor; bench drives every port
`timescale 1ns/10ps
`include "fp_priv_map.vh"
module fp_lazy_state_and_privilege_entry_bench;
    logic I_REF_CLK = 0, I_RSTN = 0, I_FP_ACC = 0, I_FP_WR = 0;
    logic I_ALT_INS = 0, I_ALT_CLR_ALL = 0, I_ALT_CLR_ONE = 0;
    logic I_PROMOTE = 0, I_PAGE_XO = 0, I_RET_BRANCH = 0, I_TRAP = 0;
    logic I_TRAP_HAS_IMM = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0;
    logic S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
    logic [6:0] I_FP_REG = 0;
    logic [7:0] I_ALT_INS_TAG = 0, I_ALT_CLR_TAG = 0;
    logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
    logic [1:0] I_PAGE_PL = 0, I_SAVED_CALLER_PL = 0, O_CPL, r;
    logic [20:0] I_TRAP_IMM = 0;
    logic [2:0] S_AXI_AWPROT = 0;
    logic [3:0] S_AXI_WSTRB = 0;
    logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, d;
    logic O_FP_ACC_OK, O_FP_FAULT, O_PROMOTE_FAULT, O_FLUSH, O_IRQ;
    logic O_TRAP_REDIRECT, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
    logic S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    int n_errors = 0, tests_run = 0, k;
    always #2 I_REF_CLK = ~I_REF_CLK;
    fp_priv_ctrl fp_priv_ctrl_i (.*);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task tmo;
        if (k >= 60) begin
            n_errors++;
            $display("Error %0t: bus timeout", $time);
            conclude;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v, input logic p);
        @(posedge I_REF_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= v;
        S_AXI_AWPROT <= {2'h0, p};
        S_AXI_WSTRB <= 4'hf;
        S_AXI_AWVALID <= 1;
        S_AXI_WVALID <= 1;
        S_AXI_BREADY <= 1;
        k = 0;
        do begin
            @(posedge I_REF_CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 0;
            k++;
        end while (!S_AXI_BVALID && k < 60);
        tmo;
        S_AXI_BREADY <= 0;
        r = S_AXI_BRESP;
    endtask
    task rd(input logic [7:0] a);
        @(posedge I_REF_CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1;
        S_AXI_RREADY <= 1;
        k = 0;
        do begin
            @(posedge I_REF_CLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
            k++;
        end while (!S_AXI_RVALID && k < 60);
        tmo;
        S_AXI_RREADY <= 0;
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
    endtask
    // drop every core pulse, then let the result settle
    task nx;
        @(posedge I_REF_CLK);
        {I_FP_ACC, I_PROMOTE, I_RET_BRANCH, I_TRAP} <= 4'h0;
        {I_ALT_INS, I_ALT_CLR_ALL, I_ALT_CLR_ONE} <= 3'h0;
        #1;
    endtask
    task fp(input logic w, input logic [6:0] n, input logic f);
        @(posedge I_REF_CLK);
        I_FP_ACC <= 1;
        I_FP_WR <= w;
        I_FP_REG <= n;
        nx;
        chk(O_FP_FAULT, f);
        chk(O_FP_ACC_OK, !f);
    endtask
    task pr(input logic x, input logic [1:0] g, s, c, input logic f);
        @(posedge I_REF_CLK);
        I_PROMOTE <= 1;
        I_PAGE_XO <= x;
        I_PAGE_PL <= g;
        I_SAVED_CALLER_PL <= s;
        nx;
        chk(O_CPL, c);
        chk(O_PROMOTE_FAULT, f);
        chk(O_FLUSH, 0);
    endtask
    task tr(input logic h, input logic [20:0] v);
        @(posedge I_REF_CLK);
        I_TRAP <= 1;
        I_TRAP_HAS_IMM <= h;
        I_TRAP_IMM <= v;
        nx;
        chk(O_FLUSH, 1);
        chk(O_TRAP_REDIRECT, 1);
        chk(O_CPL, `PL_MOST);
    endtask
    task al(input logic i, a, o, input logic [7:0] t);
        @(posedge I_REF_CLK);
        I_ALT_INS <= i;
        I_ALT_CLR_ALL <= a;
        I_ALT_CLR_ONE <= o;
        I_ALT_INS_TAG <= t;
        I_ALT_CLR_TAG <= t;
        nx;
    endtask
    task test_fp;
        rd(`OFS_STATE);
        chk(d, 32'h30);
        fp(1, 7'h01, 0);
        fp(0, 7'h02, 0);
        fp(1, 7'h1f, 0);
        rd(`OFS_STATE);
        chk(d, 32'h31);
        fp(1, 7'h20, 0);
        rd(`OFS_STATE);
        chk(d, 32'h33);
        wr(`OFS_STATE, 32'h0c, 0);
        chk(r, `RESP_OKAY);
        rd(`OFS_STATE);
        chk(d, 32'h30);
        wr(`OFS_STATE, 32'h04, 1);
        fp(0, 7'h1f, 1);
        fp(1, 7'h02, 1);
        fp(1, 7'h7f, 0);
        rd(`OFS_STATE);
        chk(d, 32'h36);
        wr(`OFS_STATE, 32'h0a, 0);
        rd(`OFS_STATE);
        chk(d, 32'h36);
        wr(`OFS_STATE, 32'h08, 1);
        fp(0, 7'h7f, 1);
        fp(1, 7'h1f, 0);
        rd(`OFS_STATE);
        chk(d, 32'h39);
        wr(`OFS_STATE, 32'h00, 1);
        $display("test_fp done");
    endtask
    task test_priv;
        pr(0, 2'h0, 2'h3, 2'h3, 1);
        pr(1, 2'h0, 2'h3, 2'h0, 0);
        wr(`OFS_MASK, 32'h0, 1);
        chk(r, `RESP_OKAY);
        pr(1, 2'h1, 2'h3, 2'h0, 1);
        @(posedge I_REF_CLK);
        I_RET_BRANCH <= 1;
        I_SAVED_CALLER_PL <= 2'h2;
        nx;
        chk(O_CPL, 2'h2);
        pr(1, 2'h1, 2'h2, 2'h1, 0);
        tr(1, 21'h1fffff);
        rd(`OFS_TRAP_IMM);
        chk(d, 32'h1fffff);
        wr(`OFS_TRAP_IMM, 32'h0, 1);
        chk(r, `RESP_SLVERR);
        rd(8'h14);
        chk(r, `RESP_SLVERR);
        $display("test_priv done");
    endtask
    task test_irq;
        rd(`OFS_EVENT);
        chk(d, 32'h7);
        rd(`OFS_MASK);
        chk(d, 32'h0);
        tr(0, 21'h0abcde);
        rd(`OFS_TRAP_IMM);
        chk(d, 32'h0);
        chk(O_IRQ, 0);
        wr(`OFS_MASK, 32'h4, 1);
        #1;
        chk(O_IRQ, 1);
        pr(1, 2'h0, 2'h0, 2'h0, 0);
        chk(O_IRQ, 1);
        rd(`OFS_EVENT);
        chk(d, 32'h4);
        @(posedge I_REF_CLK);
        #1;
        chk(O_IRQ, 0);
        $display("test_irq done");
    endtask
    task test_alt;
        al(1, 0, 0, 8'h05);
        al(1, 0, 0, 8'h06);
        al(1, 0, 0, 8'h05);
        rd(`OFS_ALT_VALID);
        chk(d, 32'h07);
        al(0, 0, 1, 8'h05);
        rd(`OFS_ALT_VALID);
        chk(d, 32'h02);
        al(1, 0, 0, 8'h09);
        al(1, 1, 0, 8'h0a);
        rd(`OFS_ALT_VALID);
        chk(d, 32'h00);
        $display("test_alt done");
    endtask
    initial begin
        repeat (20) @(posedge I_REF_CLK);
        I_RSTN <= 1;
        test_fp;
        test_priv;
        test_irq;
        test_alt;
        conclude;
    end
endmodule // fp_lazy_state_and_privilege_entry_bench

//--- bench/fp_priv_ctrl_monitor.sv
// checker for the fp lazy state and privilege entry block
// assumes it is bound to fp_priv_ctrl and sees only its ports
`timescale 1ns/10ps
module fp_priv_ctrl_monitor (
    input wire I_REF_CLK, // core clock
    input wire I_RSTN, // sync reset, active low
    input wire I_FP_ACC, // fp access
    input wire [6:0] I_FP_REG, // fp register number
    input wire O_FP_ACC_OK, // access allowed
    input wire O_FP_FAULT, // access faulted
    input wire I_PROMOTE, // promote
    input wire [1:0] I_PAGE_PL, // page privilege
    input wire I_PAGE_XO, // page execute-only
    input wire [1:0] I_SAVED_CALLER_PL, // saved caller level
    input wire I_RET_BRANCH, // return branch
    input wire I_TRAP, // trap
    input wire [1:0] O_CPL, // current level
    input wire O_PROMOTE_FAULT, // promote refused
    input wire O_FLUSH, // flush
    input wire O_TRAP_REDIRECT, // trap redirect
    input wire S_AXI_AWVALID, // aw valid
    input wire S_AXI_AWREADY, // aw ready
    input wire S_AXI_WVALID, // w valid
    input wire S_AXI_WREADY, // w ready
    input wire S_AXI_BVALID, // b valid
    input wire S_AXI_ARVALID, // ar valid
    input wire S_AXI_ARREADY, // ar ready
    input wire S_AXI_RVALID // r valid
);
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RSTN);
    sequence solo_promote;
        I_PROMOTE && !I_TRAP && !I_RET_BRANCH;
    endsequence
    sequence wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    a_low_regs_free: assert property (
        I_FP_ACC && I_FP_REG < 7'h02 |=> O_FP_ACC_OK && !O_FP_FAULT)
        else $error("fp register outside both sets was refused");
    a_fp_answer: assert property (
        I_FP_ACC |=> O_FP_FAULT != O_FP_ACC_OK)
        else $error("fp access without exactly one answer");
    a_fp_quiet: assert property (
        !I_FP_ACC |=> !O_FP_FAULT && !O_FP_ACC_OK)
        else $error("fp answer without access");
    a_promote_xo: assert property (
        solo_promote ##0 !I_PAGE_XO |=> O_PROMOTE_FAULT && $stable(O_CPL))
        else $error("promote from writable page took effect");
    a_promote_ok: assert property (
        solo_promote ##0 (I_PAGE_XO && I_SAVED_CALLER_PL <= O_CPL)
        |=> O_CPL == $past(I_PAGE_PL) && !O_PROMOTE_FAULT)
        else $error("promote did not take page level");
    a_promote_check: assert property (
        solo_promote ##0 (I_SAVED_CALLER_PL > O_CPL)
        |=> O_PROMOTE_FAULT && $stable(O_CPL))
        else $error("promote ignored saved caller level");
    a_ret_demote: assert property (
        I_RET_BRANCH && !I_TRAP && !I_PROMOTE
        |=> O_CPL == $past(I_SAVED_CALLER_PL))
        else $error("return branch did not load saved level");
    a_trap_entry: assert property (
        I_TRAP |=> O_TRAP_REDIRECT && O_FLUSH && O_CPL == 2'h0)
        else $error("trap entry incomplete");
    a_flush_cause: assert property (
        O_FLUSH |-> $past(I_TRAP))
        else $error("flush without trap");
    a_wr_answer: assert property (
        wr_taken |=> !S_AXI_AWREADY && !S_AXI_WREADY ##1 S_AXI_BVALID)
        else $error("write not answered in time");
    a_rd_answer: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read not answered in time");
endmodule // fp_priv_ctrl_monitor
bind fp_priv_ctrl fp_priv_ctrl_monitor fp_priv_ctrl_monitor_i (.*);

//--- hw/adv_load_table.v
// advanced load table: tag per entry, round-robin fill
// assumes inserts and clears come from the core on the same clock
`timescale 1ns/10ps

module adv_load_table #(
    parameter ENTRIES = 8,
    parameter IDX_W = 3,
    parameter TAG_W = 8
) (
    input wire i_clk, // core clock
    input wire i_rstn, // synchronous reset, active low
    input wire i_ins, // record an advanced load
    input wire [TAG_W-1:0] i_ins_tag, // target register of the load
    input wire i_clr_all, // invalidate every entry
    input wire i_clr_one, // invalidate entries of one register
    input wire [TAG_W-1:0] i_clr_tag, // register to invalidate
    output wire [ENTRIES-1:0] o_valid // per-entry valid bits
);
    reg [IDX_W-1:0] ptr_q;
    reg [ENTRIES-1:0] valid_q;
    reg [TAG_W-1:0] tag_q [0:ENTRIES-1];
    genvar g;

    always @(posedge i_clk) begin
        if (!i_rstn) begin
            ptr_q <= {IDX_W{1'b0}};
        end else if (i_ins && !i_clr_all) begin
            if (ptr_q == ENTRIES - 1)
                ptr_q <= {IDX_W{1'b0}};
            else
                ptr_q <= ptr_q + {{(IDX_W-1){1'b0}}, 1'b1};
        end
    end

    generate
        for (g = 0; g < ENTRIES; g = g + 1) begin : g_ent
            always @(posedge i_clk) begin
                if (!i_rstn) begin
                    valid_q[g] <= 1'b0;
                    tag_q[g] <= {TAG_W{1'b0}};
                // RULE7 clear all
                end else if (i_clr_all) begin
                    valid_q[g] <= 1'b0;
                end else if (i_ins && ptr_q == g) begin
                    valid_q[g] <= 1'b1;
                    tag_q[g] <= i_ins_tag;
                // RULE8 matching entries only
                end else if (i_clr_one && tag_q[g] == i_clr_tag) begin
                    valid_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign o_valid = valid_q;
endmodule // adv_load_table

//--- hw/fp_priv_ctrl.v
// lazy fp state tracking, load table clears and privilege entry paths
// assumes one core clock; pipeline inputs are already on this clock;
// software reaches the status bits over axi4-lite
//
// Function
// RULE1 - fp registers 2-31 form the lower set, 32-127 the upper set
// RULE2 - a write to a set's register sets that set's dirty flag
// RULE3 - both dirty flags readable and writable by unprivileged software
// RULE4 - disable bits change only on privileged writes, others ignored
// RULE5 - use of a disabled set faults instead of completing
// RULE6 - hardware never clears a dirty flag; only software writes do
// RULE7 - clear-all invalidates every load table entry at once
// RULE8 - clear-entry invalidates only entries tied to the named register
// RULE9 - promote raises privilege to the level of the code's page
// RULE10 - promote takes effect only from an execute-only page
// RULE11 - promote checks saved caller level not above current level
// RULE12 - return branch loads privilege from saved caller level
// RULE13 - promote neither masks interrupts nor moves the backing store
// RULE14 - trap flushes the pipeline; promote never flushes
// RULE15 - trap carries a 21-bit immediate that software can read
// RULE16 - trap redirects to the trap handler at most privileged level
// RULE17 - software masks interrupts after promote until stack switched
`timescale 1ns/10ps
`include "fp_priv_map.vh"

module fp_priv_ctrl #(
    parameter ALT_ENTRIES = 8,
    parameter ALT_IDX_W = 3,
    parameter TAG_W = 8
) (
    input wire I_REF_CLK, // core clock, 250 MHz
    input wire I_RSTN, // synchronous reset, active low
    // fp register access from issue
    input wire I_FP_ACC, // an fp register is read or written
    input wire I_FP_WR, // the access writes the register
    input wire [6:0] I_FP_REG, // fp register number
    output reg O_FP_ACC_OK, // access may complete
    output reg O_FP_FAULT, // disabled fp fault raised
    // advanced load table
    input wire I_ALT_INS, // advanced load recorded
    input wire [TAG_W-1:0] I_ALT_INS_TAG, // its target register
    input wire I_ALT_CLR_ALL, // clear-all instruction
    input wire I_ALT_CLR_ONE, // clear-entry instruction
    input wire [TAG_W-1:0] I_ALT_CLR_TAG, // register named by clear-entry
    // privilege entry and exit
    input wire I_PROMOTE, // promote instruction executes
    input wire [1:0] I_PAGE_PL, // privilege of the promote's page
    input wire I_PAGE_XO, // that page is execute-only
    input wire [1:0] I_SAVED_CALLER_PL, // saved caller privilege field
    input wire I_RET_BRANCH, // return branch executes
    input wire I_TRAP, // trap instruction executes
    input wire I_TRAP_HAS_IMM, // trap came in an i, f or m syllable
    input wire [20:0] I_TRAP_IMM, // trap immediate
    output reg [1:0] O_CPL, // current privilege level
    output reg O_PROMOTE_FAULT, // promote refused
    output reg O_FLUSH, // pipeline flush request
    output reg O_TRAP_REDIRECT, // fetch from trap handler
    output reg O_IRQ, // level interrupt
    // axi4-lite slave
    input wire [7:0] S_AXI_AWADDR, // write address
    input wire [2:0] S_AXI_AWPROT, // write protection, bit 0 privileged
    input wire S_AXI_AWVALID, // write address valid
    output reg S_AXI_AWREADY, // write address ready
    input wire [31:0] S_AXI_WDATA, // write data
    input wire [3:0] S_AXI_WSTRB, // write byte strobes
    input wire S_AXI_WVALID, // write data valid
    output reg S_AXI_WREADY, // write data ready
    output reg [1:0] S_AXI_BRESP, // write response
    output reg S_AXI_BVALID, // write response valid
    input wire S_AXI_BREADY, // write response ready
    input wire [7:0] S_AXI_ARADDR, // read address
    input wire S_AXI_ARVALID, // read address valid
    output reg S_AXI_ARREADY, // read address ready
    output reg [31:0] S_AXI_RDATA, // read data
    output reg [1:0] S_AXI_RRESP, // read response
    output reg S_AXI_RVALID, // read data valid
    input wire S_AXI_RREADY // read data ready
);
    // state bits: 3 upper disable, 2 lower disable, 1 upper, 0 lower dirty
    reg [3:0] state_q, state_d;
    reg [`EVENT_W-1:0] event_q, event_d;
    reg [`EVENT_W-1:0] mask_q;
    reg [20:0] trap_imm_q;
    reg [1:0] cpl_d;
    reg [7:0] wr_addr_q;
    reg wr_priv_q;
    reg [31:0] wr_data_q;
    reg [3:0] wr_strb_q;
    reg have_aw_q, have_w_q;
    wire fp_lower, fp_upper;
    wire [ALT_ENTRIES-1:0] alt_valid;
    wire wr_fire, rd_fire, rd_event;
    wire use_lo_dis, use_hi_dis, fp_blocked;
    wire promote_ok;
    wire wr_state, wr_mask;
    wire fp_write_ok, fp_fault_now, promote_bad;

    // RULE1 set membership
    fp_set_decode u_decode (
        .i_reg(I_FP_REG),
        .o_lower(fp_lower),
        .o_upper(fp_upper)
    );

    adv_load_table #(
        .ENTRIES(ALT_ENTRIES),
        .IDX_W(ALT_IDX_W),
        .TAG_W(TAG_W)
    ) u_alt (
        .i_clk(I_REF_CLK),
        .i_rstn(I_RSTN),
        .i_ins(I_ALT_INS),
        .i_ins_tag(I_ALT_INS_TAG),
        .i_clr_all(I_ALT_CLR_ALL),
        .i_clr_one(I_ALT_CLR_ONE),
        .i_clr_tag(I_ALT_CLR_TAG),
        .o_valid(alt_valid)
    );

    // RULE5 disabled set blocks the access
    assign use_lo_dis = fp_lower && state_q[`BIT_LO_DISABLE];
    assign use_hi_dis = fp_upper && state_q[`BIT_HI_DISABLE];
    assign fp_blocked = use_lo_dis || use_hi_dis;

    // RULE10 execute-only page, RULE11 caller level check
    assign promote_ok = I_PAGE_XO && (I_SAVED_CALLER_PL <= O_CPL);

    // a refused promote; a trap in the same cycle takes over
    assign promote_bad = I_PROMOTE && !I_TRAP && !promote_ok;

    // only a write that completes marks its set dirty
    assign fp_write_ok = I_FP_ACC && I_FP_WR && !fp_blocked;
    assign fp_fault_now = I_FP_ACC && fp_blocked;

    // write address and data are held until both are here
    assign wr_fire = have_aw_q && have_w_q && !S_AXI_BVALID;
    assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    assign rd_event = rd_fire && (S_AXI_ARADDR == `OFS_EVENT);

    // software write strobes, low byte lane carries every field
    assign wr_state = wr_fire && (wr_addr_q == `OFS_STATE) && wr_strb_q[0];
    assign wr_mask = wr_fire && (wr_addr_q == `OFS_MASK) && wr_strb_q[0];

    always @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_priv_q <= 1'b0;
            wr_data_q <= 32'h00000000;
            wr_strb_q <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= !have_aw_q && !S_AXI_AWREADY && !S_AXI_BVALID;
            S_AXI_WREADY <= !have_w_q && !S_AXI_WREADY && !S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                have_aw_q <= 1'b1;
                S_AXI_AWREADY <= 1'b0;
                wr_addr_q <= S_AXI_AWADDR;
                wr_priv_q <= S_AXI_AWPROT[0];
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                have_w_q <= 1'b1;
                S_AXI_WREADY <= 1'b0;
                wr_data_q <= S_AXI_WDATA;
                wr_strb_q <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                have_aw_q <= 1'b0;
                have_w_q <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                case (wr_addr_q)
                    `OFS_STATE, `OFS_EVENT, `OFS_MASK:
                        S_AXI_BRESP <= `RESP_OKAY;
                    default:
                        S_AXI_BRESP <= `RESP_SLVERR;
                endcase
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID &&
                S_AXI_ARVALID;
            if (rd_fire) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= `RESP_OKAY;
                S_AXI_RDATA <= 32'h00000000;
                case (S_AXI_ARADDR)
                    // RULE3 dirty flags read back at any level
                    `OFS_STATE:
                        S_AXI_RDATA <= {26'h0000000, O_CPL, state_q};
                    `OFS_EVENT:
                        S_AXI_RDATA <= {29'h00000000, event_q};
                    `OFS_MASK:
                        S_AXI_RDATA <= {29'h00000000, mask_q};
                    // RULE15 immediate visible to software
                    `OFS_TRAP_IMM:
                        S_AXI_RDATA <= {11'h000, trap_imm_q};
                    `OFS_ALT_VALID:
                        S_AXI_RDATA <= {{(32-ALT_ENTRIES){1'b0}},
                            alt_valid};
                    default:
                        S_AXI_RRESP <= `RESP_SLVERR;
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // status bits: software write first, hardware set on top
    always @* begin
        state_d = state_q;
        if (wr_state) begin
            // RULE3 dirty flags written from any level
            state_d[`BIT_LO_DIRTY] = wr_data_q[`BIT_LO_DIRTY];
            state_d[`BIT_HI_DIRTY] = wr_data_q[`BIT_HI_DIRTY];
            // RULE4 disable bits need a privileged write
            if (wr_priv_q) begin
                state_d[`BIT_LO_DISABLE] = wr_data_q[`BIT_LO_DISABLE];
                state_d[`BIT_HI_DISABLE] = wr_data_q[`BIT_HI_DISABLE];
            end
        end
        // RULE2 set on write, RULE6 never cleared here
        if (fp_write_ok) begin
            if (fp_lower)
                state_d[`BIT_LO_DIRTY] = 1'b1;
            if (fp_upper)
                state_d[`BIT_HI_DIRTY] = 1'b1;
        end
    end

    // sticky events; a read clears, a new event in that cycle survives
    always @* begin
        event_d = event_q;
        if (rd_event)
            event_d = {`EVENT_W{1'b0}};
        if (fp_fault_now)
            event_d[`BIT_EV_FP_FAULT] = 1'b1;
        if (promote_bad)
            event_d[`BIT_EV_PROMOTE_FAULT] = 1'b1;
        if (I_TRAP)
            event_d[`BIT_EV_TRAP] = 1'b1;
    end

    // privilege level; trap outranks promote, promote outranks return
    always @* begin
        cpl_d = O_CPL;
        if (I_TRAP) begin
            // RULE16 most privileged level
            cpl_d = `PL_MOST;
        end else if (I_PROMOTE) begin
            // RULE9 take the page level
            if (promote_ok)
                cpl_d = I_PAGE_PL;
        end else if (I_RET_BRANCH) begin
            // RULE12 demote to saved caller level
            cpl_d = I_SAVED_CALLER_PL;
        end
    end

    // status and sticky event registers
    always @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            state_q <= `RST_STATE;
            event_q <= {`EVENT_W{1'b0}};
        end else begin
            state_q <= state_d;
            event_q <= event_d;
        end
    end

    // mask register, changed by software only
    always @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            mask_q <= `RST_MASK;
        end else if (wr_mask) begin
            mask_q <= wr_data_q[`EVENT_W-1:0];
        end
    end

    // RULE13 interrupt follows events and mask, never promote
    always @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= |(event_d & mask_q);
        end
    end

    // privilege level and promote answer
    always @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            O_CPL <= `RST_CPL;
            O_PROMOTE_FAULT <= 1'b0;
        end else begin
            O_CPL <= cpl_d;
            // RULE10 RULE11 refusal reported
            O_PROMOTE_FAULT <= promote_bad;
        end
    end

    // fp access answer, one cycle after the access
    always @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            O_FP_ACC_OK <= 1'b0;
            O_FP_FAULT <= 1'b0;
        end else begin
            // RULE5 fault in place of completion
            O_FP_ACC_OK <= I_FP_ACC && !fp_blocked;
            O_FP_FAULT <= fp_fault_now;
        end
    end

    // trap entry: flush, redirect and the immediate
    always @(posedge I_REF_CLK) begin
        if (!I_RSTN) begin
            O_FLUSH <= 1'b0;
            O_TRAP_REDIRECT <= 1'b0;
            trap_imm_q <= 21'h000000;
        end else begin
            // RULE14 only the trap flushes
            O_FLUSH <= I_TRAP;
            // RULE16 enter trap handler
            O_TRAP_REDIRECT <= I_TRAP;
            // RULE15 keep the 21-bit immediate
            if (I_TRAP)
                trap_imm_q <= I_TRAP_HAS_IMM ? I_TRAP_IMM : 21'h000000;
        end
    end
endmodule // fp_priv_ctrl

//--- hw/fp_priv_map.vh
// constants for the lazy fp state and privilege entry block
// assumes a 32-bit axi4-lite register bus, byte addresses
`ifndef FP_PRIV_MAP_VH
`define FP_PRIV_MAP_VH

// register byte offsets
`define OFS_STATE 8'h00
`define OFS_EVENT 8'h04
`define OFS_MASK 8'h08
`define OFS_TRAP_IMM 8'h0c
`define OFS_ALT_VALID 8'h10

// state register fields
`define BIT_LO_DIRTY 0
`define BIT_HI_DIRTY 1
`define BIT_LO_DISABLE 2
`define BIT_HI_DISABLE 3
`define POS_CPL 4

// event register fields
`define BIT_EV_FP_FAULT 0
`define BIT_EV_PROMOTE_FAULT 1
`define BIT_EV_TRAP 2
`define EVENT_W 3

// fp register sets
`define FR_LO_FIRST 7'h02
`define FR_LO_LAST 7'h1f
`define FR_HI_FIRST 7'h20
`define FR_HI_LAST 7'h7f

// privilege levels, 0 is the most privileged
`define PL_MOST 2'h0
`define RST_CPL 2'h3
`define RST_STATE 4'h0
`define RST_MASK 3'h0

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- hw/fp_set_decode.v
// decodes an fp register number into lower or upper set membership
// assumes a 7-bit register number from the issuing pipeline stage
`timescale 1ns/10ps
`include "fp_priv_map.vh"

module fp_set_decode (
    input wire [6:0] i_reg, // fp register number
    output wire o_lower, // register is in the lower set
    output wire o_upper // register is in the upper set
);
    assign o_lower = (i_reg >= `FR_LO_FIRST) && (i_reg <= `FR_LO_LAST);
    assign o_upper = (i_reg >= `FR_HI_FIRST) && (i_reg <= `FR_HI_LAST);
endmodule // fp_set_decode
